// File: reclocker_interrupt_status.v
/*
 * Interrupt status and enable registers of the serial video reclocker,
 * reached over a classic Wishbone slave port with 32-bit data.
 * Assumes the lock, carrier and eye-threshold levels arrive from other
 * clock domains and are synchronised here before use.
 */
`timescale 1ns/100ps
`include "reclocker_irq_map.vh"
module reclocker_interrupt_status (
    // Clock and reset
    input wire clk_i,
    input wire rst_b_i,
    // Wishbone slave
    input wire cyc_i,
    input wire stb_i,
    input wire we_i,
    input wire [9:0] adr_i,
    input wire [3:0] sel_i,
    input wire [31:0] dat_i,
    output reg [31:0] dat_o,
    output reg ack_o,
    // Status levels from the receive path
    input wire cdr_lock_i,
    input wire input1_carrier_i,
    input wire selected_carrier_i,
    input wire eye_threshold_i,
    // Interrupt request
    output reg irq_o
);

// ----------------------------------------------------------------
// Input synchronisation
// ----------------------------------------------------------------
wire [`LANE_COUNT-1:0] raw_levels;
wire [`LANE_COUNT-1:0] sync_level;
wire [`LANE_COUNT-1:0] sync_rise;
wire [`LANE_COUNT-1:0] sync_fall;

assign raw_levels[`LANE_LOCK] = cdr_lock_i;
assign raw_levels[`LANE_CARRIER_IN1] = input1_carrier_i;
assign raw_levels[`LANE_CARRIER_SEL] = selected_carrier_i;
assign raw_levels[`LANE_EYE] = eye_threshold_i;

genvar lane;
generate
    for (lane = 0; lane < `LANE_COUNT; lane = lane + 1) begin : g_sync
        input_synchroniser u_sync (
            .clk_i(clk_i),
            .rst_b_i(rst_b_i),
            .async_i(raw_levels[lane]),
            .level_o(sync_level[lane]),
            .rise_o(sync_rise[lane]),
            .fall_o(sync_fall[lane])
        );
    end
endgenerate

// ----------------------------------------------------------------
// Event detection
// ----------------------------------------------------------------
wire [7:0] event_set;

assign event_set[7] = 1'b0;
assign event_set[`BIT_LOCK_GAINED] = sync_rise[`LANE_LOCK];
assign event_set[`BIT_CARRIER_FOUND] = sync_rise[`LANE_CARRIER_IN1];
assign event_set[`BIT_RESERVED4] = 1'b0;
assign event_set[`BIT_EYE_THRESHOLD] = sync_rise[`LANE_EYE];
assign event_set[`BIT_LOCK_LOST] = sync_fall[`LANE_LOCK];
assign event_set[`BIT_CARRIER_GONE] = sync_fall[`LANE_CARRIER_IN1];
assign event_set[0] = 1'b0;

// ----------------------------------------------------------------
// Bus decode
// ----------------------------------------------------------------
wire [7:0] word_index;
wire request;
wire take;
wire byte0_write;
wire hit_before;
wire hit_flags;
wire hit_after;
wire hit_enables;

assign word_index = adr_i[9:2];
assign request = cyc_i & stb_i;
// Ack lasts one cycle, so a request still held after ack is taken again
assign take = request & ~ack_o;
assign byte0_write = take & we_i & sel_i[0];
assign hit_before = (word_index == `IDX_RESERVED_BEFORE_IRQ);
assign hit_flags = (word_index == `IDX_EVENT_FLAGS);
assign hit_after = (word_index == `IDX_RESERVED_AFTER_IRQ);
assign hit_enables = (word_index == `IDX_EVENT_ENABLES);

// ----------------------------------------------------------------
// Latched event flags
// ----------------------------------------------------------------
wire flags_read;
wire [7:0] flags_write_clear;
wire [7:0] event_flags;

// Any read of the status word clears its latched event flags
assign flags_read = take & ~we_i & hit_flags;
// Write-one-to-clear as a software convenience
assign flags_write_clear = (byte0_write & hit_flags) ?
    (dat_i[7:0] & `EVENT_BITS_MASK) : 8'h00;

sticky_flags #(
    .USED_MASK(`EVENT_BITS_MASK)
) u_flags (
    .clk_i(clk_i),
    .rst_b_i(rst_b_i),
    .set_i(event_set),
    .read_clear_i(flags_read),
    .write_clear_i(flags_write_clear),
    .flags_o(event_flags)
);

// ----------------------------------------------------------------
// Event enables
// ----------------------------------------------------------------
reg [7:0] event_enables;
wire [7:0] next_event_enables;

assign next_event_enables = dat_i[7:0] & `EVENT_BITS_MASK;

always @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
        event_enables <= `RESET_EVENT_ENABLES;
    end else if (byte0_write && hit_enables) begin
        event_enables <= next_event_enables;
    end
end

// ----------------------------------------------------------------
// Status word as seen by software
// ----------------------------------------------------------------
reg [7:0] status_view;

always @* begin
    status_view = event_flags;
    status_view[`BIT_CARRIER_LIVE] = sync_level[`LANE_CARRIER_SEL];
    status_view[`BIT_RESERVED4] = 1'b0;
end

// ----------------------------------------------------------------
// Read data selection
// ----------------------------------------------------------------
reg [7:0] read_byte;

always @* begin
    if (hit_before) begin
        read_byte = `VALUE_RESERVED_BEFORE_IRQ;
    end else if (hit_flags) begin
        read_byte = status_view;
    end else if (hit_after) begin
        read_byte = `VALUE_RESERVED_AFTER_IRQ;
    end else if (hit_enables) begin
        read_byte = event_enables;
    end else begin
        // Unmapped words answer with zero
        read_byte = 8'h00;
    end
end

// ----------------------------------------------------------------
// Bus answer
// ----------------------------------------------------------------
// Registered ack: one wait cycle, keeps outputs straight from flops
always @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
        ack_o <= 1'b0;
        dat_o <= 32'h0000_0000;
    end else begin
        ack_o <= take;
        if (take && !we_i) begin
            dat_o <= {24'h00_0000, read_byte};
        end
    end
end

// ----------------------------------------------------------------
// Interrupt request
// ----------------------------------------------------------------
wire [7:0] pending;

assign pending = event_flags & event_enables & `EVENT_BITS_MASK;

always @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
        irq_o <= 1'b0;
    end else begin
        // Drops one cycle after the clearing read
        irq_o <= |pending;
    end
end

endmodule

// File: reclocker_irq_map.vh
/*
 * Register map, field positions, reset values and bus constants for the
 * reclocker interrupt status block.
 * Assumes a 32-bit classic Wishbone slave; each register occupies one
 * aligned word at byte address four times its index.
 */
// Overview of operation
// - Status bit 7 shows live carrier presence on the selected input.
// - Status bit 6 sets when the recovered-clock loop gains lock.
// - Status bit 5 sets when carrier appears on the first serial input.
// - Status bit 3 sets when eye-opening measurement reaches its threshold.
// - Status bit 2 sets when the recovered-clock loop loses lock.
// - Status bit 1 sets when carrier on the first serial input is lost.
// - Reading the status register at index 0x54 clears latched event flags.
// - Enable bit 6 gates the lock-gained interrupt; 0 blocks, 1 permits.
`ifndef RECLOCKER_IRQ_MAP_VH
`define RECLOCKER_IRQ_MAP_VH

// ----------------------------------------------------------------
// Register indices (byte address = index * 4)
// ----------------------------------------------------------------
`define IDX_RESERVED_BEFORE_IRQ 8'h53
`define IDX_EVENT_FLAGS 8'h54
`define IDX_RESERVED_AFTER_IRQ 8'h55
`define IDX_EVENT_ENABLES 8'h56

// ----------------------------------------------------------------
// Field positions, shared by flags and enables
// ----------------------------------------------------------------
`define BIT_CARRIER_LIVE 7
`define BIT_LOCK_GAINED 6
`define BIT_CARRIER_FOUND 5
`define BIT_RESERVED4 4
`define BIT_EYE_THRESHOLD 3
`define BIT_LOCK_LOST 2
`define BIT_CARRIER_GONE 1

// Bits that hold latched events
`define EVENT_BITS_MASK 8'h6E

// ----------------------------------------------------------------
// Reset and read values
// ----------------------------------------------------------------
`define RESET_EVENT_FLAGS 8'h00
`define RESET_EVENT_ENABLES 8'h00
`define VALUE_RESERVED_BEFORE_IRQ 8'h00
`define VALUE_RESERVED_AFTER_IRQ 8'h02

// ----------------------------------------------------------------
// Synchronised input lanes
// ----------------------------------------------------------------
`define LANE_LOCK 0
`define LANE_CARRIER_IN1 1
`define LANE_CARRIER_SEL 2
`define LANE_EYE 3
`define LANE_COUNT 4

`endif

// File: input_synchroniser.v
/*
 * Two-flop synchroniser for one asynchronous status level, with rising
 * and falling edge pulses taken after the second flop.
 * Assumes the input is a slow level from outside the clock domain.
 */
`timescale 1ns/100ps
module input_synchroniser (
    // Clock and reset
    input wire clk_i,
    input wire rst_b_i,
    // Asynchronous level
    input wire async_i,
    // Synchronised level and edges
    output wire level_o,
    output wire rise_o,
    output wire fall_o
);

reg meta;
reg stable;
reg previous;

// First flop feeds only the second one
always @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
        meta <= 1'b0;
        stable <= 1'b0;
        previous <= 1'b0;
    end else begin
        meta <= async_i;
        stable <= meta;
        previous <= stable;
    end
end

assign level_o = stable;
assign rise_o = stable & ~previous;
assign fall_o = ~stable & previous;

endmodule

// File: sticky_flags.v
/*
 * Eight sticky event flags. A set pulse wins over any clear in the same
 * cycle. Clears come from a whole-register read or from write-one bits.
 * Assumes set and clear inputs are synchronous to clk_i.
 */
`timescale 1ns/100ps
module sticky_flags (
    // Clock and reset
    input wire clk_i,
    input wire rst_b_i,
    // Event and clear controls
    input wire [7:0] set_i,
    input wire read_clear_i,
    input wire [7:0] write_clear_i,
    // Latched flags
    output wire [7:0] flags_o
);

parameter [7:0] USED_MASK = 8'hFF;

reg [7:0] flags;

genvar i;
generate
    for (i = 0; i < 8; i = i + 1) begin : g_flag
        if (USED_MASK[i]) begin : g_used
            always @(posedge clk_i or negedge rst_b_i) begin
                if (!rst_b_i) begin
                    flags[i] <= 1'b0;
                end else if (set_i[i]) begin
                    // Set beats clear so no event is lost
                    flags[i] <= 1'b1;
                end else if (read_clear_i || write_clear_i[i]) begin
                    flags[i] <= 1'b0;
                end
            end
        end else begin : g_unused
            always @(posedge clk_i or negedge rst_b_i) begin
                if (!rst_b_i) begin
                    flags[i] <= 1'b0;
                end else begin
                    flags[i] <= 1'b0;
                end
            end
        end
    end
endgenerate

assign flags_o = flags;

endmodule

// File: reclocker_interrupt_status_properties.sv
/* Checker for the reclocker interrupt status block.
   Sees only the top ports; keeps a shadow of the enable register. */
`timescale 1ns/100ps
module reclocker_interrupt_status_properties (
    // Clock and reset
    input wire clk_i,
    input wire rst_b_i,
    // Wishbone slave
    input wire cyc_i,
    input wire stb_i,
    input wire we_i,
    input wire [9:0] adr_i,
    input wire [3:0] sel_i,
    input wire [31:0] dat_i,
    input wire [31:0] dat_o,
    input wire ack_o,
    // Status levels and request
    input wire cdr_lock_i,
    input wire input1_carrier_i,
    input wire selected_carrier_i,
    input wire eye_threshold_i,
    input wire irq_o
);
// ----------------
// Enable shadow
// ----------------
reg [7:0] en;
always @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
        en <= 8'h00;
    end else if (cyc_i && stb_i && !ack_o && we_i && sel_i[0]
                 && adr_i[9:2] == 8'h56) begin
        en <= dat_i[7:0] & 8'h6E;
    end
end
default clocking @(posedge clk_i); endclocking
default disable iff (!rst_b_i);
property p_answer;
    cyc_i && stb_i && !ack_o |=> ack_o ##1 !ack_o;
endproperty
a_answer: assert property (p_answer)
    else $error("bus answer not one cycle");
property p_reserved;
    ack_o && !$past(we_i) && $past(adr_i[9:2]) == 8'h54
        |-> dat_o[4] == 1'h0 && dat_o[31:8] == 24'h0;
endproperty
a_reserved: assert property (p_reserved)
    else $error("reserved status bits set");
property p_gate;
    en == 8'h00 && $past(en) == 8'h00 |-> !irq_o;
endproperty
a_gate: assert property (p_gate)
    else $error("request with all enables off");
property p_lock_gain;
    $rose(cdr_lock_i) && en[6] |-> ##[1:6] irq_o;
endproperty
a_lock_gain: assert property (p_lock_gain)
    else $error("no request after lock gained");
property p_car_found;
    $rose(input1_carrier_i) && en[5] |-> ##[1:6] irq_o;
endproperty
a_car_found: assert property (p_car_found)
    else $error("no request after carrier found");
property p_eye;
    $rose(eye_threshold_i) && en[3] |-> ##[1:6] irq_o;
endproperty
a_eye: assert property (p_eye)
    else $error("no request after eye threshold");
property p_lock_lost;
    $fell(cdr_lock_i) && en[2] |-> ##[1:6] irq_o;
endproperty
a_lock_lost: assert property (p_lock_lost)
    else $error("no request after lock lost");
property p_car_gone;
    $fell(input1_carrier_i) && en[1] |-> ##[1:6] irq_o;
endproperty
a_car_gone: assert property (p_car_gone)
    else $error("no request after carrier gone");
endmodule
bind reclocker_interrupt_status reclocker_interrupt_status_properties
    reclocker_interrupt_status_properties_inst (.clk_i(clk_i),
    .rst_b_i(rst_b_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i),
    .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o),
    .ack_o(ack_o), .cdr_lock_i(cdr_lock_i),
    .input1_carrier_i(input1_carrier_i),
    .selected_carrier_i(selected_carrier_i),
    .eye_threshold_i(eye_threshold_i), .irq_o(irq_o));

// File: reclocker_interrupt_status_test.sv
/* Self-checking bench for the reclocker interrupt status block.
   Drives Wishbone and status levels itself from one 125 MHz clock. */
`timescale 1ns/100ps
module reclocker_interrupt_status_test;
reg clk_i = 1'h0, rst_b_i = 1'h0, cyc_i = 1'h0, stb_i = 1'h0;
reg we_i = 1'h0, cdr_lock_i = 1'h0, input1_carrier_i = 1'h0;
reg selected_carrier_i = 1'h0, eye_threshold_i = 1'h0;
reg [9:0] adr_i = 10'h000;
reg [3:0] sel_i = 4'h0;
reg [31:0] dat_i = 32'h0, rd;
wire [31:0] dat_o;
wire ack_o, irq_o;
integer miscompares = 0, comparisons = 0, cycles = 0;
reclocker_interrupt_status reclocker_interrupt_status_inst (
    .clk_i(clk_i), .rst_b_i(rst_b_i), .cyc_i(cyc_i), .stb_i(stb_i),
    .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i),
    .dat_o(dat_o), .ack_o(ack_o), .cdr_lock_i(cdr_lock_i),
    .input1_carrier_i(input1_carrier_i),
    .selected_carrier_i(selected_carrier_i),
    .eye_threshold_i(eye_threshold_i), .irq_o(irq_o));
// ----------------
// Clock, timeout, helpers
// ----------------
initial begin
    forever #4 clk_i = ~clk_i;
end
always @(posedge clk_i) begin
    cycles <= cycles + 1;
    if (cycles == 3000) begin
        miscompares = miscompares + 1;
        summarize;
    end
end
task summarize;
    begin
        if (miscompares == 0 && comparisons > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    end
endtask
task check(input [63:0] name, input [31:0] seen, input [31:0] exp);
    begin
        comparisons = comparisons + 1;
        if (seen !== exp) begin
            miscompares = miscompares + 1;
            $display("wrong value %0s expected %h seen %h", name, exp, seen);
        end
    end
endtask
// Holds the request until ack is sampled, then releases for a cycle
task wb(input w, input [9:0] a, input [31:0] d);
    begin
        @(posedge clk_i);
        cyc_i <= 1'h1;
        stb_i <= 1'h1;
        we_i <= w;
        adr_i <= a;
        sel_i <= 4'hF;
        dat_i <= d;
        // Only the bench timeout ends a wait that never sees ack
        while (ack_o !== 1'h1) begin
            @(posedge clk_i);
        end
        rd = dat_o;
        cyc_i <= 1'h0;
        stb_i <= 1'h0;
    end
endtask
task settle(input integer n);
    begin
        repeat (n) @(posedge clk_i);
    end
endtask
// ----------------
// Scenarios
// ----------------
task test_reset;
    begin
        wb(1'h0, 10'h150, 32'h0);
        check("status", rd, 32'h00);
        wb(1'h0, 10'h158, 32'h0);
        check("enables", rd, 32'h00);
        wb(1'h0, 10'h14C, 32'h0);
        check("rsvd53", rd, 32'h00);
        wb(1'h0, 10'h154, 32'h0);
        check("rsvd55", rd, 32'h02);
        wb(1'h1, 10'h158, 32'hFF);
        wb(1'h0, 10'h158, 32'h0);
        check("enables", rd, 32'h6E);
    end
endtask
task test_events;
    begin
        cdr_lock_i <= 1'h1;
        input1_carrier_i <= 1'h1;
        eye_threshold_i <= 1'h1;
        selected_carrier_i <= 1'h1;
        settle(8);
        check("irq", irq_o, 1'h1);
        wb(1'h0, 10'h150, 32'h0);
        check("status", rd, 32'hE8);
        settle(2);
        check("irq", irq_o, 1'h0);
        wb(1'h0, 10'h150, 32'h0);
        check("status", rd, 32'h80);
        cdr_lock_i <= 1'h0;
        input1_carrier_i <= 1'h0;
        selected_carrier_i <= 1'h0;
        settle(8);
        wb(1'h0, 10'h150, 32'h0);
        check("status", rd, 32'h06);
    end
endtask
task test_gate;
    begin
        wb(1'h1, 10'h158, 32'h00);
        cdr_lock_i <= 1'h1;
        settle(8);
        check("irq", irq_o, 1'h0);
        wb(1'h1, 10'h158, 32'h40);
        settle(2);
        check("irq", irq_o, 1'h1);
        wb(1'h0, 10'h150, 32'h0);
        check("status", rd, 32'h40);
        settle(2);
        check("irq", irq_o, 1'h0);
    end
endtask
// Write-one-to-clear per bit, then a reset in mid-run
task test_clear_reset;
    begin
        wb(1'h1, 10'h158, 32'hFF);
        eye_threshold_i <= 1'h0;
        cdr_lock_i <= 1'h0;
        settle(8);
        check("irq", irq_o, 1'h1);
        wb(1'h1, 10'h150, 32'h02);
        settle(2);
        check("irq", irq_o, 1'h1);
        wb(1'h1, 10'h150, 32'h04);
        settle(2);
        check("irq", irq_o, 1'h0);
        eye_threshold_i <= 1'h1;
        settle(8);
        check("irq", irq_o, 1'h1);
        // Eye level dropped with reset so no false edge follows release
        rst_b_i <= 1'h0;
        eye_threshold_i <= 1'h0;
        settle(2);
        check("irq", irq_o, 1'h0);
        rst_b_i <= 1'h1;
        wb(1'h0, 10'h150, 32'h0);
        check("status", rd, 32'h00);
        wb(1'h0, 10'h158, 32'h0);
        check("enables", rd, 32'h00);
    end
endtask
initial begin
    settle(10);
    rst_b_i <= 1'h1;
    test_reset;
    test_events;
    test_gate;
    test_clear_reset;
    summarize;
end
endmodule
